// >>> verilog/rail_seq_config.sv
`timescale 1ns/1ps
`default_nettype none
module rail_seq_config
	import rail_seq_pkg::*;
#(
	parameter logic [TW-1:0] SHORT_CYC = TW'(SHORT_GAP_CYC),
	parameter logic [TW-1:0] LONG_CYC  = TW'(LONG_GAP_CYC)
)(
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             unlock_i,
	input  wire logic             reg_wr_i,
	input  wire logic             reg_rd_i,
	input  wire logic [7:0]       reg_addr_i,
	input  wire logic [7:0]       reg_wdata_i,
	output var  logic [7:0]       reg_rdata_o,
	input  wire logic             pwr_up_req_i,
	input  wire logic             pwr_dn_req_i,
	output var  logic             strobe_o,
	output var  logic [3:0]       strobe_num_o,
	output var  logic             busy_o,
	output var  logic [RAILS-1:0] rail_en_o
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	cfg_t          cfg_r;
	seq_state_t    state_r;
	logic          up_r;
	logic          tmr_start_r;
	logic [TW-1:0] tmr_load_r;
	logic          tmr_done;
	logic [3:0]    next_num;
	logic          fire;
	logic [TW-1:0] gap_nxt;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_r.gap[7:0] <= GAP_LOW_RST;
			cfg_r.gap[8]   <= GAP_HIGH_RST[GAP9_BIT];
			cfg_r.factor   <= GAP_HIGH_RST[FACTOR_BIT];
			cfg_r.slot     <= {BUCK34_RST, BUCK12_RST};
		end else if (reg_wr_i && unlock_i) begin
			unique case (reg_addr_i)
				GAP_LOW_ADDR: cfg_r.gap[7:0] <= reg_wdata_i;
				GAP_HIGH_ADDR: begin
					cfg_r.gap[8] <= reg_wdata_i[GAP9_BIT];
					cfg_r.factor <= reg_wdata_i[FACTOR_BIT];
				end
				BUCK12_ADDR: cfg_r.slot[1:0] <= {reg_wdata_i[7:4], reg_wdata_i[3:0]};
				BUCK34_ADDR: cfg_r.slot[3:2] <= {reg_wdata_i[7:4], reg_wdata_i[3:0]};
				default: ;
			endcase
		end
	end

	// Reserved bits of the second timing register read as zero
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				GAP_LOW_ADDR:  reg_rdata_o <= cfg_r.gap[7:0];
				GAP_HIGH_ADDR: reg_rdata_o <= {cfg_r.factor, 6'h00, cfg_r.gap[8]};
				BUCK12_ADDR:   reg_rdata_o <= {cfg_r.slot[1], cfg_r.slot[0]};
				BUCK34_ADDR:   reg_rdata_o <= {cfg_r.slot[3], cfg_r.slot[2]};
				default:       reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Gap following the strobe just fired: after n going up, before n-1 going down
	always_comb begin
		logic       bit_sel;
		logic [3:0] gi;
		bit_sel = 1'b0;
		gi      = up_r ? next_num - 4'h1 : next_num - 4'h2;
		if (gi < 4'h9) begin
			bit_sel = cfg_r.gap[gi];
		end
		gap_nxt = bit_sel ? LONG_CYC : SHORT_CYC;
		if (!up_r && cfg_r.factor) begin
			gap_nxt = TW'(gap_nxt * DOWN_SCALE);
		end
	end

	always_comb begin
		fire     = 1'b0;
		next_num = strobe_num_o;
		if (state_r == S_IDLE) begin
			fire     = pwr_up_req_i || pwr_dn_req_i;
			next_num = pwr_up_req_i ? FIRST_STROBE : LAST_STROBE;
		end else if (tmr_done) begin
			fire     = 1'b1;
			next_num = up_r ? strobe_num_o + 4'h1 : strobe_num_o - 4'h1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			up_r <= 1'b1;
		end else if (state_r == S_IDLE && fire) begin
			up_r <= pwr_up_req_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r      <= S_IDLE;
			busy_o       <= 1'b0;
			strobe_o     <= 1'b0;
			strobe_num_o <= 4'h0;
			tmr_start_r  <= 1'b0;
			tmr_load_r   <= '0;
		end else begin
			strobe_o    <= fire;
			tmr_start_r <= 1'b0;
			if (fire) begin
				strobe_num_o <= next_num;
				if ((up_r || state_r == S_IDLE) && state_r != S_IDLE && next_num == LAST_STROBE
					|| state_r != S_IDLE && !up_r && next_num == FIRST_STROBE) begin
					state_r <= S_IDLE;
					busy_o  <= 1'b0;
				end else begin
					state_r <= S_GAP;
					busy_o  <= 1'b1;
				end
			end
			if (strobe_o && state_r == S_GAP) begin
				tmr_start_r <= 1'b1;
				tmr_load_r  <= gap_nxt;
			end
		end
	end

	gap_timer u_timer (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.start_i (tmr_start_r),
		.load_i  (tmr_load_r),
		.done_o  (tmr_done)
	);

	// ----------------------------------------------------------------
	// Rail enables
	// ----------------------------------------------------------------
	genvar r;
	generate
		for (r = 0; r < RAILS; r++) begin : g_rail
			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					rail_en_o[r] <= 1'b0;
				end else if (strobe_o && strobe_num_o == cfg_r.slot[r]
					&& cfg_r.slot[r] >= MIN_SLOT && cfg_r.slot[r] <= LAST_STROBE) begin
					rail_en_o[r] <= up_r;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_locked_write_ignored: assert property (@(posedge clk_i) disable iff (!nrst_i)
		reg_wr_i && !unlock_i |=> $stable(cfg_r))
		else $error("locked write changed configuration");
	a_slot_reg_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
		reg_rd_i && reg_addr_i == BUCK12_ADDR && !reg_wr_i
		|=> reg_rdata_o == {$past(cfg_r.slot[1]), $past(cfg_r.slot[0])})
		else $error("rail slot readback wrong");
	a_up_gap_value: assert property (@(posedge clk_i) disable iff (!nrst_i)
		tmr_start_r && up_r && strobe_num_o < 4'h9
		|-> tmr_load_r == (cfg_r.gap[strobe_num_o - 4'h1] ? LONG_CYC : SHORT_CYC))
		else $error("power-up gap length wrong");
	a_gap_nine_value: assert property (@(posedge clk_i) disable iff (!nrst_i)
		tmr_start_r && up_r && strobe_num_o == 4'h9
		|-> tmr_load_r == (cfg_r.gap[8] ? LONG_CYC : SHORT_CYC))
		else $error("gap after strobe nine wrong");
	a_down_scaled: assert property (@(posedge clk_i) disable iff (!nrst_i)
		tmr_start_r && !up_r && cfg_r.factor
		|-> tmr_load_r == TW'(DOWN_SCALE * SHORT_CYC) || tmr_load_r == TW'(DOWN_SCALE * LONG_CYC))
		else $error("power-down gap not scaled");
	a_strobe_order: assert property (@(posedge clk_i) disable iff (!nrst_i)
		strobe_o && busy_o && $past(busy_o) |-> strobe_num_o == (up_r
			? $past(strobe_num_o) + 4'h1 : $past(strobe_num_o) - 4'h1) || $past(strobe_o))
		else $error("strobe order broken");
	a_rail_on_slot: assert property (@(posedge clk_i) disable iff (!nrst_i)
		strobe_o && up_r && strobe_num_o == cfg_r.slot[0] && cfg_r.slot[0] >= MIN_SLOT
		&& cfg_r.slot[0] <= LAST_STROBE |=> rail_en_o[0])
		else $error("rail not enabled at its strobe");
	a_rail_unowned: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(cfg_r.slot[1] < MIN_SLOT || cfg_r.slot[1] > LAST_STROBE) |=> $stable(rail_en_o[1]))
		else $error("sequencer moved an unowned rail");
	a_idle_up_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_r == S_IDLE && pwr_up_req_i
		|=> strobe_o && strobe_num_o == FIRST_STROBE && up_r)
		else $error("power-up did not start at the first strobe");
	a_idle_down_last: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_r == S_IDLE && pwr_dn_req_i && !pwr_up_req_i
		|=> strobe_o && strobe_num_o == LAST_STROBE && !up_r)
		else $error("power-down did not start at the last strobe");
	// Requests arriving mid-sequence must not sneak in an extra strobe
	a_no_early_strobe: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_r == S_GAP && !tmr_done |=> !strobe_o)
		else $error("strobe issued before its gap ran out");
	a_down_unscaled: assert property (@(posedge clk_i) disable iff (!nrst_i)
		tmr_start_r && !up_r && !cfg_r.factor
		|-> tmr_load_r == SHORT_CYC || tmr_load_r == LONG_CYC)
		else $error("power-down gap scaled with multiplier clear");
	a_unlocked_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
		reg_wr_i && unlock_i && reg_addr_i == GAP_LOW_ADDR
		|=> cfg_r.gap[7:0] == $past(reg_wdata_i))
		else $error("unlocked write did not land");
	a_rail_off_down: assert property (@(posedge clk_i) disable iff (!nrst_i)
		strobe_o && !up_r && strobe_num_o == cfg_r.slot[0] && cfg_r.slot[0] >= MIN_SLOT
		&& cfg_r.slot[0] <= LAST_STROBE |=> !rail_en_o[0])
		else $error("rail not released at its power-down strobe");
	a_reserved_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
		reg_rd_i && reg_addr_i == GAP_HIGH_ADDR |=> reg_rdata_o[6:1] == 6'h00)
		else $error("reserved timing bits read non-zero");

endmodule // rail_seq_config
`default_nettype wire

// >>> verilog/rail_seq_pkg.sv
`default_nettype none
package rail_seq_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] GAP_LOW_ADDR   = 8'h20;
	localparam logic [7:0] GAP_HIGH_ADDR  = 8'h21;
	localparam logic [7:0] BUCK12_ADDR    = 8'h22;
	localparam logic [7:0] BUCK34_ADDR    = 8'h23;
	localparam logic [7:0] GAP_LOW_RST    = 8'h06;
	localparam logic [7:0] GAP_HIGH_RST   = 8'h00;
	localparam logic [7:0] BUCK12_RST     = 8'h94;
	localparam logic [7:0] BUCK34_RST     = 8'h8A;
	localparam int         FACTOR_BIT     = 7;
	localparam int         GAP9_BIT       = 0;

	// ----------------------------------------------------------------
	// Strobes and timing
	// ----------------------------------------------------------------
	localparam int         RAILS          = 4;
	localparam logic [3:0] FIRST_STROBE   = 4'h1;
	localparam logic [3:0] LAST_STROBE    = 4'hA;
	localparam logic [3:0] MIN_SLOT       = 4'h3;
	localparam int         CLK_HZ         = 200_000_000;
	localparam int         SHORT_GAP_MS   = 2;
	localparam int         LONG_GAP_MS    = 5;
	localparam int         SHORT_GAP_CYC  = SHORT_GAP_MS * (CLK_HZ / 1000);
	localparam int         LONG_GAP_CYC   = LONG_GAP_MS * (CLK_HZ / 1000);
	localparam int         DOWN_SCALE     = 10;
	localparam int         TW             = 24;

	typedef struct packed {
		logic                  factor;
		logic [8:0]            gap;
		logic [RAILS-1:0][3:0] slot;
	} cfg_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_GAP  = 2'b01
	} seq_state_t;

endpackage
`default_nettype wire

// >>> verilog/gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module gap_timer
	import rail_seq_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	input  wire logic          start_i,
	input  wire logic [TW-1:0] load_i,
	output var  logic          done_o
);
	logic [TW-1:0] cnt_r;
	logic          running_r;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r     <= '0;
			running_r <= 1'b0;
			done_o    <= 1'b0;
		end else if (start_i) begin
			cnt_r     <= load_i - TW'(1);
			running_r <= 1'b1;
			done_o    <= 1'b0;
		end else if (running_r && cnt_r == '0) begin
			running_r <= 1'b0;
			done_o    <= 1'b1;
		end else begin
			cnt_r     <= running_r ? cnt_r - TW'(1) : cnt_r;
			done_o    <= 1'b0;
		end
	end

	a_done_after_run: assert property (@(posedge clk_i) disable iff (!nrst_i)
		done_o |-> $past(running_r) && !running_r)
		else $error("timer done without a running count");

endmodule // gap_timer
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       clk_i,
	output var  logic       unlock_o,
	output var  logic       wr_o,
	output var  logic       rd_o,
	output var  logic [7:0] addr_o,
	output var  logic [7:0] wdata_o,
	input  wire logic [7:0] rdata_i
);
	// ------------------------------------------------
	// Management bus master, drives on falling edges
	// ------------------------------------------------
	initial begin
		unlock_o = 1'b0;
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 1'b0;
		// Idle data is inverted so a stale value never looks valid
		wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		rd_o = 1'b1;
		addr_o = a;
		@(negedge clk_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask
endmodule // host_model
`default_nettype wire

// >>> tb/rail_seq_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rail_seq_config_tb;
	import rail_seq_pkg::*;
	localparam int SH = 4;
	localparam int LG = 10;
	logic             clk_i, nrst_i, unlock, wr, rd, up_req, dn_req, strobe, busy;
	logic [7:0]       addr, wdata, rdata, v;
	logic [3:0]       num;
	logic [RAILS-1:0] rails;
	int               failures, n_tests;

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	rail_seq_config #(.SHORT_CYC(TW'(SH)), .LONG_CYC(TW'(LG))) rail_seq_config_inst (
		.clk_i(clk_i), .nrst_i(nrst_i), .unlock_i(unlock), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.pwr_up_req_i(up_req), .pwr_dn_req_i(dn_req), .strobe_o(strobe),
		.strobe_num_o(num), .busy_o(busy), .rail_en_o(rails)
	);

	host_model host_model_inst (
		.clk_i(clk_i), .unlock_o(unlock), .wr_o(wr), .rd_o(rd),
		.addr_o(addr), .wdata_o(wdata), .rdata_i(rdata)
	);

	// ------------------------------------------------
	// Checking helpers
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host_model_inst.rd(a, v);
		chk(32'(v), 32'(e));
	endtask

	// Runs one whole sequence and times every strobe after the first against the gap bits
	task automatic seq(input logic up, input logic [8:0] g, input logic f);
		int c;
		int s;
		int e;
		@(negedge clk_i);
		up_req = up;
		dn_req = ~up;
		@(negedge clk_i);
		up_req = 1'b0;
		dn_req = 1'b0;
		// The first strobe already stands at the edge where the request drops
		for (int k = 1; k <= 10; k++) begin
			c = 0;
			if (k > 1) begin
				do begin
					@(negedge clk_i);
					c++;
				end while (strobe !== 1'b1 && c < 2000);
			end
			chk(32'(strobe), 32'h1);
			s = up ? k : 11 - k;
			chk(32'(num), 32'(s));
			if (k > 1) begin
				e = (g[up ? s - 2 : s - 1] ? LG : SH) * ((!up && f) ? DOWN_SCALE : 1) + 3;
				chk(32'(c), 32'(e));
			end
		end
		chk(32'(busy), 32'h0);
		@(negedge clk_i);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#50000;
		failures++;
		conclude();
	end

	// ------------------------------------------------
	// Test sequence
	// ------------------------------------------------
	initial begin
		nrst_i = 1'b0;
		up_req = 1'b0;
		dn_req = 1'b0;
		failures = 0;
		n_tests = 0;
		repeat (3) @(negedge clk_i);
		nrst_i = 1'b1;
		rchk(GAP_LOW_ADDR, 8'h06);
		rchk(GAP_HIGH_ADDR, 8'h00);
		rchk(BUCK12_ADDR, 8'h94);
		rchk(BUCK34_ADDR, 8'h8A);
		rchk(8'h24, 8'h00);
		host_model_inst.wr(GAP_LOW_ADDR, 8'hFF);
		rchk(GAP_LOW_ADDR, 8'h06);
		$display("test reset values and lock done");
		host_model_inst.unlock_o = 1'b1;
		host_model_inst.wr(GAP_HIGH_ADDR, 8'hFF);
		rchk(GAP_HIGH_ADDR, 8'h81);
		host_model_inst.wr(GAP_LOW_ADDR, 8'h35);
		host_model_inst.wr(BUCK12_ADDR, 8'hB4);
		rchk(BUCK12_ADDR, 8'hB4);
		$display("test register writes done");
		seq(1'b1, 9'h135, 1'b1);
		chk(32'(rails), 32'hD);
		$display("test power-up done");
		seq(1'b0, 9'h135, 1'b1);
		chk(32'(rails), 32'h0);
		$display("test power-down done");
		host_model_inst.wr(GAP_HIGH_ADDR, 8'h01);
		rchk(GAP_HIGH_ADDR, 8'h01);
		seq(1'b0, 9'h135, 1'b0);
		chk(32'(rails), 32'h0);
		$display("test unscaled power-down done");
		conclude();
	end
endmodule // rail_seq_config_tb
`default_nettype wire
